// ===== hdl/ptcc_channel.v
`timescale 1ns/100ps
`include "ptcc_defines.vh"

// One counter block: run/stop, clear, compare B wrap, one-shot stop.
module ptcc_channel #(
  parameter CW = `PTCC_CW,
  parameter HALF_CAP = 1
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire ce,
  input wire tick,
  input wire tick_fall,
  input wire run_set,
  input wire run_clr,
  input wire clr_req,
  input wire count_mode_sel,
  input wire [CW-1:0] compare_b_reg,
  output reg running,
  output reg clr_busy,
  output reg [CW-1:0] count_value,
  output reg [CW:0] dual_count,
  output reg cmp_b_evt
);

  wire hit_b = (count_value == compare_b_reg);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      clr_busy <= 1'b0;
      count_value <= `PTCC_CNT_ZERO;
      dual_count <= `PTCC_DUAL_ZERO;
      cmp_b_evt <= 1'b0;
    end else if (ce) begin
      cmp_b_evt <= 1'b0;
      if (run_set)
        running <= 1'b1;
      else if (run_clr)
        running <= 1'b0;
      if (HALF_CAP != 0) begin
        // Clear waits for a count clock edge, busy flag shows progress
        if (clr_req)
          clr_busy <= 1'b1;
        else if (clr_busy && tick) begin
          clr_busy <= 1'b0;
          count_value <= `PTCC_CNT_ZERO;
          dual_count <= `PTCC_DUAL_ZERO;
        end
      end else if (clr_req) begin
        count_value <= `PTCC_CNT_ZERO;
        dual_count <= `PTCC_DUAL_ZERO;
      end
      if (running && !clr_busy && !clr_req) begin
        if (tick) begin
          if (hit_b) begin
            cmp_b_evt <= 1'b1;
            if (count_mode_sel == `PTCC_MODE_ONESHOT)
              running <= 1'b0;
            // Basic one-shot parks on its last count until cleared
            if (HALF_CAP != 0 || count_mode_sel != `PTCC_MODE_ONESHOT) begin
              count_value <= `PTCC_CNT_ZERO;
              dual_count <= `PTCC_DUAL_ZERO;
            end
          end else begin
            count_value <= count_value + `PTCC_CNT_ONE;
            dual_count <= dual_count + `PTCC_DUAL_ONE;
          end
        end else if (tick_fall && !hit_b) begin
          dual_count <= dual_count + `PTCC_DUAL_ONE;
        end
      end
    end
  end

endmodule

// ===== hdl/ptcc_defines.vh
`ifndef PTCC_DEFINES_VH
`define PTCC_DEFINES_VH

`define PTCC_NCH 4
`define PTCC_CW 16
`define PTCC_SELW 2
`define PTCC_SEL_RST 2'h0
`define PTCC_CNT_ZERO 16'h0000
`define PTCC_CNT_ONE 16'h0001
`define PTCC_DUAL_ZERO 17'h00000
`define PTCC_DUAL_ONE 17'h00001
`define PTCC_MODE_REPEAT 1'b0
`define PTCC_MODE_ONESHOT 1'b1

`endif

// ===== hdl/ptcc_top.v
`timescale 1ns/100ps
`include "ptcc_defines.vh"


module ptcc_top #(
  parameter NCH = `PTCC_NCH,
  parameter CW = `PTCC_CW,
  parameter HALF_CAP = 1
) (
  input wire sys_clk,
  input wire sys_rst,
  input wire ce,
  input wire [NCH-1:0] count_clk_en,
  input wire [NCH-1:0] count_clk_fall_en,
  input wire shared_counter_mode,
  input wire [NCH-1:0] count_mode_sel,
  input wire [NCH-1:0] half_step_mode,
  input wire [NCH-1:0] run_wr,
  input wire [NCH-1:0] run_wdata,
  input wire [NCH-1:0] clear_wr,
  input wire [NCH*`PTCC_SELW-1:0] counter_select,
  input wire [NCH*CW-1:0] compare_a_reg,
  input wire [NCH*CW-1:0] compare_b_reg,
  output reg [NCH-1:0] counter_run,
  output reg [NCH-1:0] clear_busy,
  output reg [NCH*CW-1:0] count_value_reg,
  output reg [NCH-1:0] compare_a_evt,
  output reg [NCH-1:0] compare_b_evt
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [CW-1:0] pick_word;
    input [NCH*CW-1:0] bus;
    input [`PTCC_SELW-1:0] idx;
    integer k;
    begin
      pick_word = {CW{1'b0}};
      for (k = 0; k < NCH; k = k + 1)
        if (idx == k[`PTCC_SELW-1:0])
          pick_word = bus[k*CW +: CW];
    end
  endfunction

  function pick_bit;
    input [NCH-1:0] bus;
    input [`PTCC_SELW-1:0] idx;
    integer k;
    begin
      pick_bit = 1'b0;
      for (k = 0; k < NCH; k = k + 1)
        if (idx == k[`PTCC_SELW-1:0])
          pick_bit = bus[k];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counter blocks

  wire [NCH-1:0] running;
  wire [NCH-1:0] busy;
  wire [NCH*CW-1:0] cnt;
  wire [NCH*(CW+1)-1:0] dual; // Never reaches a port
  wire [NCH-1:0] b_evt;
  wire [NCH-1:0] tick;
  wire [NCH-1:0] tick_f;

  // Shared mode forces channel 0's clock onto every counter
  assign tick = shared_counter_mode ? {NCH{count_clk_en[0]}}
                                    : count_clk_en;
  assign tick_f = shared_counter_mode ? {NCH{count_clk_fall_en[0]}}
                                      : count_clk_fall_en;

  // Compare B per counter uses the comparator of the same channel;
  // cross routing picks the count a full-step comparator watches and the run bit gating it; half step uses its own dual count.
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      ptcc_channel #(
        .CW(CW),
        .HALF_CAP(HALF_CAP)
      ) u_ch (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .tick(tick[g]),
        .tick_fall(tick_f[g] & (HALF_CAP != 0)),
        .run_set(run_wr[g] & run_wdata[g]),
        .run_clr(run_wr[g] & ~run_wdata[g]),
        .clr_req(clear_wr[g]),
        .count_mode_sel(count_mode_sel[g]),
        .compare_b_reg(compare_b_reg[g*CW +: CW]),
        .running(running[g]),
        .clr_busy(busy[g]),
        .count_value(cnt[g*CW +: CW]),
        .dual_count(dual[g*(CW+1) +: CW+1]),
        .cmp_b_evt(b_evt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Comparator side: routed counter, compare A source

  reg [NCH-1:0] next_a_evt;
  reg [NCH-1:0] prev_match;
  reg [NCH-1:0] next_match;
  integer i;
  reg [`PTCC_SELW-1:0] sel;
  reg [CW-1:0] rc;
  reg [CW-1:0] ca;
  reg [CW:0] rd;
  reg hs;

  always @* begin
    sel = `PTCC_SEL_RST;
    rc = {CW{1'b0}};
    ca = {CW{1'b0}};
    rd = {(CW+1){1'b0}};
    hs = 1'b0;
    next_a_evt = {NCH{1'b0}};
    next_match = {NCH{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      sel = counter_select[i*`PTCC_SELW +: `PTCC_SELW];
      rc = pick_word(cnt, sel);
      rd = dual[(i * (CW + 1)) +: CW + 1];
      ca = compare_a_reg[i*CW +: CW];
      hs = half_step_mode[i] && (HALF_CAP != 0);
      if (hs)
        next_match[i] = (rd[CW-1:0] == ca);
      else
        next_match[i] = (rc == ca);
      // Fire once per match entry, only while the counter is live
      next_a_evt[i] = next_match[i] && !prev_match[i]
                      && pick_bit(running, sel);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      counter_run <= {NCH{1'b0}};
      clear_busy <= {NCH{1'b0}};
      count_value_reg <= {(NCH*CW){1'b0}};
      compare_a_evt <= {NCH{1'b0}};
      compare_b_evt <= {NCH{1'b0}};
      prev_match <= {NCH{1'b0}};
    end else if (ce) begin
      counter_run <= running;
      clear_busy <= busy;
      // Whole word registered at once so a read never tears
      count_value_reg <= cnt;
      compare_a_evt <= next_a_evt;
      compare_b_evt <= b_evt;
      prev_match <= next_match;
    end
  end

endmodule

// ===== verification/ptcc_properties.sv
`timescale 1ns/100ps
module ptcc_checker #(parameter NCH = 4, parameter CW = 16) (
  input wire sys_clk,
  input wire sys_rst,
  input wire [NCH-1:0] run_wr,
  input wire [NCH-1:0] run_wdata,
  input wire [NCH-1:0] clear_wr,
  input wire [NCH-1:0] count_mode_sel,
  input wire [NCH-1:0] half_step_mode,
  input wire [NCH*2-1:0] counter_select,
  input wire [NCH*CW-1:0] compare_a_reg,
  input wire [NCH-1:0] counter_run,
  input wire [NCH-1:0] clear_busy,
  input wire [NCH*CW-1:0] count_value_reg,
  input wire [NCH-1:0] compare_a_evt,
  input wire [NCH-1:0] compare_b_evt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [CW-1:0] c0 = count_value_reg[CW-1:0];
  sequence s_idle;
    !counter_run[0] && !clear_busy[0] && !clear_wr[0];
  endsequence
  sequence s_wrap_ch1;
    compare_b_evt[1] && count_mode_sel[1];
  endsequence
  a_stop_hold: assert property (s_idle [*3] |-> $stable(c0))
    else $error("count moved while stopped");
  a_run_start: assert property (run_wr[0] && run_wdata[0]
    |-> ##2 counter_run[0])
    else $error("run write did not start");
  a_run_stop: assert property (run_wr[0] && !run_wdata[0]
    |-> ##2 !counter_run[0])
    else $error("stop write did not stop");
  a_wrap_zero: assert property (compare_b_evt[0]
    |-> c0 == 16'h0000)
    else $error("compare B without return to zero");
  a_oneshot_stop: assert property (s_wrap_ch1
    |-> ##[0:2] !counter_run[1])
    else $error("one-shot kept running");
  a_repeat_run: assert property (compare_b_evt[0]
    && !count_mode_sel[0] && !$past(run_wr[0])
    && !$past(run_wr[0], 2) |-> counter_run[0])
    else $error("repeat mode stopped at wrap");
  a_count_step: assert property (!$stable(c0) |->
    c0 == $past(c0) + 16'h0001 || c0 == 16'h0000)
    else $error("count moved by other than one");
  a_cmpa_match: assert property (compare_a_evt[0]
    && !half_step_mode[0] && counter_select[1:0] == 2'h0
    |-> c0 == compare_a_reg[CW-1:0])
    else $error("compare A off its value");
  a_clear_zero: assert property ($fell(clear_busy[0])
    |-> ##[0:1] c0 == 16'h0000)
    else $error("clear ended with nonzero count");
endmodule
bind ptcc_top ptcc_checker #(.NCH(NCH), .CW(CW)) u_chk (.*);

// ===== verification/tb_pwm_timer_counter_control.sv
`timescale 1ns/100ps
module tb_pwm_timer_counter_control;
  reg sys_clk = 0, sys_rst = 1, shm = 0;
  reg [3:0] ck = 0, ckf = 0, hs = 0, mode = 4'h2, rw = 0, rd = 0, cw = 0;
  reg [3:0] aev = 0, bev = 0;
  reg [63:0] cb = 0;
  wire [3:0] run, busy, aevt, bevt;
  wire [63:0] cnt;
  integer fail_count = 0, n_compared = 0, k, e, t2 = 0, b2;
  always #4 sys_clk = ~sys_clk;
  ptcc_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(1'b1),
    .count_clk_en(ck), .count_clk_fall_en(ckf),
    .shared_counter_mode(shm), .count_mode_sel(mode),
    .half_step_mode(hs), .run_wr(rw), .run_wdata(rd), .clear_wr(cw),
    .counter_select(8'hE4), .compare_a_reg(64'h0000000000000002),
    .compare_b_reg(cb), .counter_run(run), .clear_busy(busy),
    .count_value_reg(cnt), .compare_a_evt(aevt), .compare_b_evt(bevt));
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task step(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Strobe, catch the one-cycle events while they stand, then wait
  // two more cycles; the count reached the output register on the same edge as the events
  task tk(input [3:0] m, input [3:0] f);
    ck = m;
    ckf = f;
    step(1);
    ck = 0;
    ckf = 0;
    step(1);
    aev = aevt;
    bev = bevt;
    step(2);
  endtask
  task wr_run(input [3:0] m, input [3:0] v);
    rw = m;
    rd = v;
    step(1);
    rw = 0;
    step(2);
  endtask
  function [15:0] model(input integer t, input integer b);
    model = t % (b + 1);
  endfunction
  function [15:0] flag(input b);
    flag = b ? 16'h0001 : 16'h0000;
  endfunction
  initial begin
    e = $urandom(32'hD777);
    b2 = $urandom % 8 + 1;
    step(10);
    sys_rst = 0;
    chk("run", {12'h000, run}, 16'h0000);
    // Modes first, then clear and a clock to finish it, then compare values
    cw = 4'hF;
    step(1);
    cw = 0;
    tk(4'hF, 4'h0);
    chk("busy", {12'h000, busy}, 16'h0000);
    cb = {16'h0004, b2[15:0], 16'h0003, 16'h0005};
    tk(4'hF, 4'h0);
    wr_run(4'hF, 4'hF);
    chk("run", {12'h000, run}, 16'h000F);
    for (k = 1; k <= 14; k++) begin
      e = $urandom % 2;
      t2 = t2 + e;
      tk({1'b0, e[0], 2'b01}, 4'h0);
      chk("c0", cnt[15:0], model(k, 5));
      chk("c2", cnt[47:32], model(t2, b2));
      chk("a0", {15'h0000, aev[0]}, flag(model(k, 5) == 16'h0002));
      chk("b0", {15'h0000, bev[0]}, flag(model(k, 5) == 16'h0000));
    end
    chk("run0", {15'h0000, run[0]}, 16'h0001);
    for (k = 0; k < 6; k++) tk(4'h2, 4'h0);
    chk("run1", {15'h0000, run[1]}, 16'h0000);
    chk("c1", cnt[31:16], 16'h0000);
    wr_run(4'h1, 4'h0);
    tk(4'h1, 4'h0);
    chk("c0", cnt[15:0], model(14, 5));
    wr_run(4'h1, 4'h1);
    tk(4'h1, 4'h0);
    chk("c0", cnt[15:0], model(15, 5));
    wr_run(4'h1, 4'h0);
    cw = 4'h1;
    step(1);
    cw = 0;
    step(1);
    chk("busy0", {15'h0000, busy[0]}, 16'h0001);
    ck = 4'h1;
    for (e = 0; e < 20 && busy[0] !== 1'b0; e++) step(1);
    ck = 0;
    if (e == 20) fail_count++;
    else begin
      step(2);
      chk("c0", cnt[15:0], 16'h0000);
      // Half step on running counter 0, comparator use only
      hs = 4'h1;
      wr_run(4'h1, 4'h1);
      tk(4'h1, 4'h0);
      chk("a0h", {15'h0000, aev[0]}, 16'h0000);
      tk(4'h0, 4'h1);
      chk("a0h", {15'h0000, aev[0]}, 16'h0001);
      chk("c0", cnt[15:0], 16'h0001);
      wr_run(4'hF, 4'h0);
      hs = 4'h0;
      shm = 1;
      mode = 4'h0;
      wr_run(4'h2, 4'h2);
      tk(4'h2, 4'h0);
      chk("c1", cnt[31:16], 16'h0000);
      tk(4'h1, 4'h0);
      chk("c1", cnt[31:16], 16'h0001);
    end
    tally_and_finish;
  end
endmodule
